// ### logic/sbc_core.sv
// serial port core: clock source select, baud divisor, auto-baud, framing and parity
// assumes source ticks come from logic on clk_sys_i; serial pins are asynchronous
// Contract
// - clock select bit zero picks pll tick or crystal tick for baud
// - divisor is five high-register bits above eight low-register bits
// - zero divisor produces no baud tick at all
// - bit rate is source rate over sixteen times divisor
// - loop bit joins transmit path to receive input
// - in loop mode single bit drives transmit pin while a frame is sent and receives on it otherwise; without single bit the pin is unused
// - stop bit selects one or two stop bits both directions
// - nine bit selects eight or nine bit frames, lsb first
// - eight-bit parity: bit seven carries parity of bits zero to six
// - nine-bit parity: ninth bit carries parity of eight data bits
// - parity select picks odd when set, even when clear
// - auto-baud measures a 0x55 byte and writes divisor registers
// - auto-baud matches once; clear and set the bit to rearm
// - enable bit clear stops and resets the functional logic
// - registers stay readable and writable while disabled
// - mode, stop, enable, clock and divisor settings hold in frame mode
// - received ninth bit readable, transmit ninth bit writable in control three
`timescale 1ns/10ps
module sbc_core
  import sbc_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       pll_tick_i,
  input  wire logic       xtal_tick_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output sbc_word_s       rx_word_o,
  output logic            rx_valid_o,
  input  wire logic       rxd_i,
  input  wire logic       txd_in_i,
  output logic            txd_o,
  output logic            txd_oe_o
);
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  logic [7:0]          ctrl_one_reg;
  logic                clk_sel_reg;
  logic                tx_ninth_reg;
  logic                rx_ninth_reg;
  logic [2:0]          status_reg;
  logic [4:0]          baud_high_reg;
  logic [7:0]          baud_low_reg;
  logic [7:0]          rdata_reg;
  logic [DIV_W-1:0]    div_w;
  logic                func_rst;
  logic                src_tick;
  logic [DIV_W-1:0]    baud_cnt_reg;
  logic                os_tick_reg;
  sbc_word_s           buf_mem_reg [BUF_DEPTH];
  logic [PTR_W-1:0]    buf_wr_reg;
  logic [PTR_W-1:0]    buf_rd_reg;
  logic [PTR_W:0]      buf_cnt_reg;
  logic                buf_push;
  logic                buf_pop;
  logic                buf_valid;
  sbc_tx_e             tx_state_reg;
  logic [3:0]          tx_sub_reg;
  logic [2:0]          tx_bit_reg;
  sbc_word_s           tx_shift_reg;
  logic                tx_line_reg;
  sbc_word_s           tx_load;
  logic                tx_bit_end;
  logic                pin_mux;
  logic                sync1_reg;
  logic                sync2_reg;
  logic                rx_line;
  logic                rx_prev_reg;
  logic                rx_fall;
  sbc_rx_e             rx_state_reg;
  logic [3:0]          rx_sub_reg;
  logic [2:0]          rx_bit_reg;
  sbc_word_s           rx_shift_reg;
  sbc_word_s           rx_word_reg;
  logic                rx_valid_reg;
  logic                rx_done;
  logic                rx_par_bad;
  logic                rx_frm_bad;
  sbc_ab_e             ab_state_reg;
  logic                ab_armed_reg;
  logic [AB_CNT_W-1:0] ab_cnt_reg;
  logic [AB_CNT_W-1:0] ab_sum;
  logic [2:0]          ab_edge_reg;
  logic [DIV_W-1:0]    ab_result_reg;
  logic                ab_load;
  logic                wr_ctrl_one;

  // parity bit that makes the character's count of ones even, or odd when asked
  function automatic logic par_of(input logic [7:0] bits, input logic odd);
    par_of = (^bits) ^ odd;
  endfunction

  // decoded settings, also in force in frame mode
  assign div_w       = {baud_high_reg, baud_low_reg};
  assign func_rst    = !rst_n_i || !ctrl_one_reg[C1_ENABLE];
  assign src_tick    = clk_sel_reg ? xtal_tick_i : pll_tick_i;
  assign wr_ctrl_one = wr_i && (addr_i == OFS_CTRL_ONE);

  // configuration registers, kept by the system reset only
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_one_reg <= RST_CTRL_ONE;
      clk_sel_reg  <= 1'b0;
      tx_ninth_reg <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_CTRL_ONE)
        ctrl_one_reg <= wdata_i;
      if (addr_i == OFS_CLK_SEL)
        clk_sel_reg <= wdata_i[0];
      if (addr_i == OFS_CTRL_THREE)
        tx_ninth_reg <= wdata_i[C3_TX_NINTH];
    end
  end

  // divisor registers; a finished auto-baud match overwrites them
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      baud_high_reg <= RST_DIVISOR[12:8];
      baud_low_reg  <= RST_DIVISOR[7:0];
    end
    else if (ab_load)
    begin
      baud_high_reg <= ab_result_reg[12:8];
      baud_low_reg  <= ab_result_reg[7:0];
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_BAUD_HIGH)
        baud_high_reg <= wdata_i[4:0];
      if (addr_i == OFS_BAUD_LOW)
        baud_low_reg <= wdata_i;
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      status_reg <= 3'h0;
    else
      status_reg <= (status_reg & ~((wr_i && addr_i == OFS_STATUS) ? wdata_i[2:0] : 3'h0))
                    | {ab_load, rx_done && rx_frm_bad, rx_done && rx_par_bad};
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 8'h00;
    else if (rd_i)
      case (addr_i)
        OFS_CTRL_ONE:   rdata_reg <= ctrl_one_reg;
        OFS_CTRL_THREE: rdata_reg <= {rx_ninth_reg, tx_ninth_reg, 6'h00};
        OFS_STATUS:     rdata_reg <= {5'h00, status_reg};
        OFS_CLK_SEL:    rdata_reg <= {7'h00, clk_sel_reg};
        OFS_BAUD_HIGH:  rdata_reg <= {3'h0, baud_high_reg};
        OFS_BAUD_LOW:   rdata_reg <= baud_low_reg;
        default:        rdata_reg <= 8'h00;
      endcase
    else
      rdata_reg <= 8'h00;
  end
  assign rdata_o = rdata_reg;

  // oversample tick: one per divisor source ticks, none for a zero divisor
  always_ff @(posedge clk_sys_i)
  begin
    if (func_rst || div_w == '0)
    begin
      baud_cnt_reg <= '0;
      os_tick_reg  <= 1'b0;
    end
    else if (src_tick && baud_cnt_reg >= div_w - 13'h0001)
    begin
      baud_cnt_reg <= '0;
      os_tick_reg  <= 1'b1;
    end
    else
    begin
      baud_cnt_reg <= baud_cnt_reg + {12'h000, src_tick};
      os_tick_reg  <= 1'b0;
    end
  end

  // two-entry transmit buffer; the transmitter drains it one frame at a time
  assign tx_ready_o = (buf_cnt_reg < (PTR_W + 1)'(BUF_DEPTH));
  assign buf_valid  = (buf_cnt_reg != '0);
  assign buf_push   = tx_valid_i && tx_ready_o;
  assign buf_pop    = buf_valid && os_tick_reg && (tx_state_reg == TX_IDLE);
  always_ff @(posedge clk_sys_i)
  begin
    if (func_rst)
    begin
      buf_wr_reg  <= '0;
      buf_rd_reg  <= '0;
      buf_cnt_reg <= '0;
    end
    else
    begin
      if (buf_push)
        buf_wr_reg <= (buf_wr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : buf_wr_reg + 1'b1;
      if (buf_pop)
        buf_rd_reg <= (buf_rd_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : buf_rd_reg + 1'b1;
      buf_cnt_reg <= buf_cnt_reg + {{PTR_W{1'b0}}, buf_push} - {{PTR_W{1'b0}}, buf_pop};
    end
  end

  // buffer storage, one entry per slot
  for (genvar gi = 0; gi < BUF_DEPTH; gi++)
  begin : g_buf
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        buf_mem_reg[gi] <= '0;
      else if (buf_push && buf_wr_reg == PTR_W'(gi))
        buf_mem_reg[gi] <= '{data: tx_data_i, ninth: tx_ninth_reg};
    end
  end

  // frame contents with parity folded in
  always_comb
  begin
    tx_load = buf_mem_reg[buf_rd_reg];
    if (ctrl_one_reg[C1_PAR_EN] && !ctrl_one_reg[C1_NINE])
      tx_load.data[7] = par_of({1'b0, tx_load.data[6:0]}, ctrl_one_reg[C1_PAR_ODD]);
    if (ctrl_one_reg[C1_PAR_EN] && ctrl_one_reg[C1_NINE])
      tx_load.ninth = par_of(tx_load.data, ctrl_one_reg[C1_PAR_ODD]);
  end
  assign tx_bit_end = os_tick_reg && (tx_sub_reg == LAST_SAMPLE);

  // transmitter: start, eight data bits lsb first, optional ninth, stops
  always_ff @(posedge clk_sys_i)
  begin
    if (func_rst)
    begin
      tx_state_reg <= TX_IDLE;
      tx_sub_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= '0;
      tx_line_reg  <= 1'b1;
    end
    else
    begin
      if (os_tick_reg)
        tx_sub_reg <= (tx_state_reg == TX_IDLE) ? 4'h0 : tx_sub_reg + 4'h1;
      case (tx_state_reg)
        TX_IDLE:
          if (buf_pop)
          begin
            tx_shift_reg <= tx_load;
            tx_line_reg  <= 1'b0;
            tx_state_reg <= TX_START;
          end
        TX_START:
          if (tx_bit_end)
          begin
            tx_line_reg  <= tx_shift_reg.data[0];
            tx_shift_reg <= {1'b0, tx_shift_reg.data[7:1], tx_shift_reg.ninth};
            tx_bit_reg   <= 3'h0;
            tx_state_reg <= TX_DATA;
          end
        TX_DATA:
          if (tx_bit_end)
          begin
            if (tx_bit_reg == LAST_DATA)
            begin
              tx_bit_reg   <= 3'h0;
              tx_line_reg  <= ctrl_one_reg[C1_NINE] ? tx_shift_reg.ninth : 1'b1;
              tx_state_reg <= ctrl_one_reg[C1_NINE] ? TX_NINTH : TX_STOP;
            end
            else
            begin
              tx_bit_reg   <= tx_bit_reg + 3'h1;
              tx_line_reg  <= tx_shift_reg.data[0];
              tx_shift_reg <= {1'b0, tx_shift_reg.data[7:1], tx_shift_reg.ninth};
            end
          end
        TX_NINTH:
          if (tx_bit_end)
          begin
            tx_line_reg  <= 1'b1;
            tx_state_reg <= TX_STOP;
          end
        TX_STOP:
          if (tx_bit_end)
          begin
            if (tx_bit_reg == {2'b00, ctrl_one_reg[C1_STOP2]})
            begin
              tx_bit_reg   <= 3'h0;
              tx_state_reg <= TX_IDLE;
            end
            else
              tx_bit_reg <= tx_bit_reg + 3'h1;
          end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // pin routing: normal, internal loop with pin unused, or single wire
  assign txd_o    = tx_line_reg;
  assign txd_oe_o = !ctrl_one_reg[C1_LOOP] ||
                    (ctrl_one_reg[C1_SINGLE] && tx_state_reg != TX_IDLE);
  assign pin_mux  = (ctrl_one_reg[C1_LOOP] && ctrl_one_reg[C1_SINGLE]) ? txd_in_i : rxd_i;

  // two-flop synchroniser on the receive pin
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_mux;
      sync2_reg <= sync1_reg;
    end
  end
  assign rx_line = (ctrl_one_reg[C1_LOOP] && !ctrl_one_reg[C1_SINGLE]) ?
                   tx_line_reg : sync2_reg;
  assign rx_fall = rx_prev_reg && !rx_line;

  // received frame checks
  assign rx_done    = (rx_state_reg == RX_STOP) && os_tick_reg && (rx_sub_reg == LAST_SAMPLE)
                      && (rx_bit_reg == {2'b00, ctrl_one_reg[C1_STOP2]});
  assign rx_frm_bad = !rx_line;
  assign rx_par_bad = ctrl_one_reg[C1_PAR_EN] && (ctrl_one_reg[C1_NINE] ?
                      (par_of(rx_shift_reg.data, ctrl_one_reg[C1_PAR_ODD]) != rx_shift_reg.ninth) :
                      (par_of({1'b0, rx_shift_reg.data[6:0]}, ctrl_one_reg[C1_PAR_ODD])
                       != rx_shift_reg.data[7]));

  // receiver: mid-bit sampling, realigned on every start edge
  always_ff @(posedge clk_sys_i)
  begin
    if (func_rst)
    begin
      rx_state_reg <= RX_IDLE;
      rx_sub_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= '0;
      rx_prev_reg  <= 1'b1;
      rx_word_reg  <= '0;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      rx_prev_reg  <= rx_line;
      rx_valid_reg <= rx_done;
      if (os_tick_reg)
        rx_sub_reg <= rx_sub_reg + 4'h1;
      case (rx_state_reg)
        RX_IDLE:
          if (rx_fall)
          begin
            rx_sub_reg   <= 4'h0;
            rx_state_reg <= RX_START;
          end
        RX_START:
          if (os_tick_reg && rx_sub_reg == MID_SAMPLE)
          begin
            rx_sub_reg   <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (os_tick_reg && rx_sub_reg == LAST_SAMPLE)
          begin
            rx_shift_reg.data <= {rx_line, rx_shift_reg.data[7:1]};
            rx_bit_reg        <= (rx_bit_reg == LAST_DATA) ? 3'h0 : rx_bit_reg + 3'h1;
            if (rx_bit_reg == LAST_DATA)
              rx_state_reg <= ctrl_one_reg[C1_NINE] ? RX_NINTH : RX_STOP;
          end
        RX_NINTH:
          if (os_tick_reg && rx_sub_reg == LAST_SAMPLE)
          begin
            rx_shift_reg.ninth <= rx_line;
            rx_state_reg       <= RX_STOP;
          end
        RX_STOP:
          if (rx_done)
          begin
            rx_word_reg  <= rx_shift_reg;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= RX_IDLE;
          end
          else if (os_tick_reg && rx_sub_reg == LAST_SAMPLE)
            rx_bit_reg <= rx_bit_reg + 3'h1;
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  assign rx_word_o  = rx_word_reg;
  assign rx_valid_o = rx_valid_reg;

  // received ninth bit, readable in control three
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rx_ninth_reg <= 1'b0;
    else if (rx_done && ctrl_one_reg[C1_NINE])
      rx_ninth_reg <= rx_shift_reg.ninth;
  end

  // auto-baud arming: a rising auto-baud bit arms one match
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ab_armed_reg <= 1'b0;
    else if (ab_load)
      ab_armed_reg <= 1'b0;
    else if (wr_ctrl_one && wdata_i[C1_ABAUD] && !ctrl_one_reg[C1_ABAUD])
      ab_armed_reg <= 1'b1;
    else if (!ctrl_one_reg[C1_ABAUD])
      ab_armed_reg <= 1'b0;
  end

  // auto-baud measure: source ticks over eight bits of the sync byte
  assign ab_load = (ab_state_reg == AB_FINISH) && !rx_prev_reg && rx_line;
  assign ab_sum  = ab_cnt_reg + {{(AB_CNT_W - 1){1'b0}}, src_tick}; // count incl. this edge
  always_ff @(posedge clk_sys_i)
  begin
    if (func_rst)
    begin
      ab_state_reg  <= AB_IDLE;
      ab_cnt_reg    <= '0;
      ab_edge_reg   <= 3'h0;
      ab_result_reg <= '0;
    end
    else
      case (ab_state_reg)
        AB_IDLE:
          if (ab_armed_reg && rx_fall)
          begin
            ab_cnt_reg   <= '0;
            ab_edge_reg  <= 3'h0;
            ab_state_reg <= AB_MEASURE;
          end
        AB_MEASURE:
        begin
          ab_cnt_reg <= ab_sum;
          if (rx_fall)
          begin
            ab_edge_reg <= ab_edge_reg + 3'h1;
            if (ab_edge_reg == AB_EDGES - 3'h1)
            begin
              ab_result_reg <= ab_sum[AB_CNT_W-1:AB_SHIFT];
              ab_state_reg  <= AB_FINISH;
            end
          end
        end
        AB_FINISH:
          if (ab_load)
            ab_state_reg <= AB_IDLE;
        default:
          ab_state_reg <= AB_IDLE;
      endcase
  end

  // checks on the driven behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  zero_div_tick_a: assert property ((div_w == '0) |=> !os_tick_reg)
    else $error("baud tick with zero divisor");
  tick_spacing_a: assert property ((os_tick_reg && div_w > 13'h0001) |=> !os_tick_reg)
    else $error("baud ticks too close");
  disabled_idle_a: assert property (!ctrl_one_reg[C1_ENABLE] |=>
    (tx_state_reg == TX_IDLE && rx_state_reg == RX_IDLE && tx_line_reg))
    else $error("logic active while disabled");
  normal_pin_a: assert property (!ctrl_one_reg[C1_LOOP] |-> txd_oe_o)
    else $error("transmit pin not driven in normal mode");
  loop_pin_a: assert property ((ctrl_one_reg[C1_LOOP] && !ctrl_one_reg[C1_SINGLE])
    |-> (!txd_oe_o && rx_line == tx_line_reg))
    else $error("internal loop wrong");
  start_low_a: assert property ($rose(tx_state_reg != TX_IDLE) |-> !tx_line_reg)
    else $error("start bit not low");
  stop_high_a: assert property ((tx_state_reg == TX_STOP) |-> tx_line_reg)
    else $error("stop bit not high");
  abaud_load_a: assert property (ab_load |=>
    (div_w == $past(ab_result_reg) && !ab_armed_reg && status_reg[ST_AB_DONE]))
    else $error("auto-baud result not loaded once");
  parity_flag_a: assert property ((rx_done && rx_par_bad) |=> status_reg[ST_PAR_ERR])
    else $error("parity error not flagged");
  rx_ninth_a: assert property ((rx_done && ctrl_one_reg[C1_NINE])
    |=> (rx_ninth_reg == rx_word_reg.ninth && rx_valid_o))
    else $error("ninth bit not kept");

  tx_frame_c: cover property ((tx_state_reg == TX_STOP) ##1 (tx_state_reg == TX_IDLE));
  rx_frame_c: cover property (rx_done && ctrl_one_reg[C1_NINE]);
  abaud_c:    cover property (ab_load);
  buf_full_c: cover property (!tx_ready_o && tx_valid_i);
endmodule

// ### logic/sbc_pkg.sv
// constants, types and register map of the serial baud and frame configuration core
// assumes an 8-bit register port with 16-bit addresses and a single system clock
package sbc_pkg;
  // register addresses
  localparam logic [15:0] OFS_CTRL_ONE   = 16'h00b5;
  localparam logic [15:0] OFS_CTRL_THREE = 16'h00b9;
  localparam logic [15:0] OFS_STATUS     = 16'h00bc;
  localparam logic [15:0] OFS_CLK_SEL    = 16'h205d;
  localparam logic [15:0] OFS_BAUD_HIGH  = 16'h2070;
  localparam logic [15:0] OFS_BAUD_LOW   = 16'h2071;
  // values after reset
  localparam logic [7:0]  RST_CTRL_ONE   = 8'h00;
  localparam logic [12:0] RST_DIVISOR    = 13'h0000;
  // control one fields
  localparam int C1_LOOP    = 7;
  localparam int C1_STOP2   = 6;
  localparam int C1_SINGLE  = 5;
  localparam int C1_NINE    = 4;
  localparam int C1_PAR_EN  = 3;
  localparam int C1_PAR_ODD = 2;
  localparam int C1_ABAUD   = 1;
  localparam int C1_ENABLE  = 0;
  // control three and status fields
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int ST_PAR_ERR  = 0;
  localparam int ST_FRM_ERR  = 1;
  localparam int ST_AB_DONE  = 2;
  // bit timing in oversample ticks, sixteen to a bit
  localparam logic [3:0] MID_SAMPLE  = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [2:0] LAST_DATA   = 3'h7;
  // auto-baud: four more falling edges of the sync byte span eight bits
  localparam logic [2:0] AB_EDGES = 3'h4;
  localparam int         AB_CNT_W = 20;
  localparam int         AB_SHIFT = 7;
  localparam int         DIV_W    = 13;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } sbc_word_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP  = 3'b100
  } sbc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP  = 3'b100
  } sbc_rx_e;

  typedef enum logic [1:0] {
    AB_IDLE    = 2'b00,
    AB_MEASURE = 2'b01,
    AB_FINISH  = 2'b10
  } sbc_ab_e;
endpackage

// ### verification/sbc_core_tb.sv
// self-checking bench of the serial baud and frame core
// assumes a remote node on the receive pin and the crystal tick at half rate
`timescale 1ns/10ps
module sbc_core_tb;
  import sbc_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, tx_data = 8'h00, rd_v;
  logic pll_t = 1'b1, xtal_t = 1'b0, tx_valid = 1'b0, tx_ready, rx_valid;
  logic txd, txd_oe, node_line;
  logic [10:0] f;
  sbc_word_s rx_word;
  int errors = 0, checks_done = 0;
  wire txd_pin = txd_oe ? txd : node_line;

  sbc_core sbc_core_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .pll_tick_i(pll_t),
    .xtal_tick_i(xtal_t), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_word_o(rx_word), .rx_valid_o(rx_valid),
    .rxd_i(node_line), .txd_in_i(txd_pin), .txd_o(txd), .txd_oe_o(txd_oe));
  sbc_remote_node sbc_remote_node_inst (.clk_sys_i(clk_sys_i), .line_o(node_line));

  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) xtal_t <= ~xtal_t;

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // register write, spaced so frame setup writes never crowd each other
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    repeat (11) @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 rd_v = rdata;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge clk_sys_i);
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge clk_sys_i);
    tx_valid <= 1'b0;
  endtask
  // waits for a start bit on the pin, then samples n bits at mid-bit
  task automatic capture(input int n, input int b);
    for (int i = 0; i < 3000 && txd !== 1'b0; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    repeat (b / 2) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++)
    begin
      #1 f[i] = txd;
      repeat (b) @(posedge clk_sys_i);
    end
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && rx_valid !== 1'b1; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    check({8'h00, rx_valid}, 9'h001);
  endtask

  task automatic t_regs();
    logic [15:0] ra [4] = '{OFS_CTRL_ONE, OFS_CLK_SEL, OFS_BAUD_HIGH, OFS_BAUD_LOW};
    foreach (ra[i])
    begin
      rd(ra[i]);
      check({1'b0, rd_v}, 9'h000);
    end
    wr(OFS_BAUD_HIGH, 8'hff);
    rd(OFS_BAUD_HIGH);
    check({1'b0, rd_v}, 9'h01f);
    wr(OFS_CLK_SEL, 8'hff);
    rd(OFS_CLK_SEL);
    check({1'b0, rd_v}, 9'h001);
    rd(16'h1234);
    check({1'b0, rd_v}, 9'h000);
    wr(OFS_CLK_SEL, 8'h00);
    wr(OFS_BAUD_HIGH, 8'h00);
  endtask
  task automatic t_zero();
    wr(OFS_CTRL_ONE, 8'h01);
    push(8'h5a);
    push(8'h5b);
    #1 check({8'h00, tx_ready}, 9'h000);
    repeat (300) @(posedge clk_sys_i);
    check({8'h00, txd}, 9'h001);
    wr(OFS_CTRL_ONE, 8'h00);
    @(posedge clk_sys_i);
    #1 check({8'h00, tx_ready}, 9'h001);
  endtask
  task automatic t_tx8();
    wr(OFS_BAUD_LOW, 8'h01);
    wr(OFS_CTRL_ONE, 8'h0d);
    push(8'h35);
    capture(10, 16);
    check({f[9], f[8:1]}, {1'b1, 8'hb5});
    check({8'h00, f[0]}, 9'h000);
  endtask
  task automatic t_tx9();
    wr(OFS_CTRL_ONE, 8'h59);
    push(8'h07);
    capture(11, 16);
    check(f[9:1], {1'b1, 8'h07});
    check({7'h00, f[10], f[0]}, 9'h002);
    fork
      sbc_remote_node_inst.send({1'b1, 8'ha6}, 9, 16);
      wait_rx();
    join
    check(rx_word, {8'ha6, 1'b1});
    rd(OFS_CTRL_THREE);
    check({8'h00, rd_v[C3_RX_NINTH]}, 9'h001);
    rd(OFS_STATUS);
    check({8'h00, rd_v[ST_PAR_ERR]}, 9'h001);
  endtask
  task automatic t_rx_xtal();
    wr(OFS_CLK_SEL, 8'h01);
    wr(OFS_CTRL_ONE, 8'h01);
    fork
      sbc_remote_node_inst.send(9'h0c3, 8, 32);
      wait_rx();
    join
    check({1'b0, rx_word.data}, 9'h0c3);
    wr(OFS_CLK_SEL, 8'h00);
  endtask
  task automatic t_loop();
    wr(OFS_CTRL_ONE, 8'h81);
    #1 check({8'h00, txd_oe}, 9'h000);
    push(8'h96);
    wait_rx();
    check({1'b0, rx_word.data}, 9'h096);
    wr(OFS_CTRL_ONE, 8'h01);
  endtask
  // first match takes, a second sync is ignored until the bit is rearmed
  task automatic t_abaud();
    wr(OFS_CTRL_ONE, 8'h03);
    sbc_remote_node_inst.send(9'h155, 9, 80);
    rd(OFS_BAUD_LOW);
    check({1'b0, rd_v}, 9'h005);
    rd(OFS_STATUS);
    check({8'h00, rd_v[ST_AB_DONE]}, 9'h001);
    sbc_remote_node_inst.send(9'h155, 9, 48);
    rd(OFS_BAUD_LOW);
    check({1'b0, rd_v}, 9'h005);
    wr(OFS_CTRL_ONE, 8'h01);
    wr(OFS_CTRL_ONE, 8'h03);
    sbc_remote_node_inst.send(9'h155, 9, 48);
    rd(OFS_BAUD_LOW);
    check({1'b0, rd_v}, 9'h003);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_zero();
    t_tx8();
    t_tx9();
    t_rx_xtal();
    t_loop();
    t_abaud();
    give_verdict();
  end
  initial
  begin
    #600us;
    errors++;
    give_verdict();
  end
endmodule

// ### verification/sbc_remote_node.sv
// remote serial node: drives its line with frames, idles high between them
// assumes the bench calls send with a bit period given in system clocks
`timescale 1ns/10ps
module sbc_remote_node (
  input  wire logic clk_sys_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  // start bit, n bits lsb first, then the line returns to its idle high
  task automatic send(input logic [8:0] d, input int n, input int p);
    line_o <= 1'b0;
    repeat (p) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= d[i];
      repeat (p) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
    repeat (3 * p) @(posedge clk_sys_i);
  endtask
endmodule
